// File: bench/dpa_mem_model.sv
// dpa_mem_model: sdram command bus model, open row per bank
// assumes one command per clock; counts faults and accesses
`timescale 1ns/1ps
module dpa_mem_model
    import dpa_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0] cmd_in,
    input wire logic [DPA_BANK_W-1:0] bank_in,
    input wire logic [DPA_ROW_W-1:0] row_in,
    input wire logic flag_in,
    output int err_out,
    output int acc_out,
    output int flag_out,
    output int close_out,
    output logic probe_out
);
    logic [7:0] open_b;
    logic [DPA_ROW_W-1:0] row_b [8];
    int shut_t [8];
    int cyc;
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (!rst_b_in) begin
            open_b <= '0;
            err_out <= 0;
            acc_out <= 0;
            flag_out <= 0;
            close_out <= 0;
        end else if (cmd_in == DPA_CMD_ACT) begin
            // open only idle bank after precharge
            if (open_b[bank_in] || cyc - shut_t[bank_in] < DPA_TRP_CYC)
                err_out <= err_out + 1;
            open_b[bank_in] <= 1'b1;
            row_b[bank_in] <= row_in;
        end else if (cmd_in == DPA_CMD_CLOSE) begin
            close_out <= close_out + 1;
            open_b[bank_in] <= 1'b0;
            shut_t[bank_in] <= cyc;
        end else if (cmd_in == DPA_CMD_RD || cmd_in == DPA_CMD_WR) begin
            if (!open_b[bank_in] || row_b[bank_in] != row_in)
                err_out <= err_out + 1;
            acc_out <= acc_out + 1;
            flag_out <= flag_out + flag_in;
            if (bank_in == '0 && row_in == '0)
                probe_out <= flag_in;
            if (flag_in) begin
                open_b[bank_in] <= 1'b0;
                shut_t[bank_in] <= cyc;
            end
        end
    end
endmodule

// File: bench/dpa_sched_checker.sv
// dpa_sched_checker: assertions on the scheduler command port
// assumes binding to dpa_sched; open rows are rebuilt from the commands
`timescale 1ns/1ps
module dpa_sched_checker
    import dpa_pkg::*;
#(
    parameter int BANK_W = DPA_BANK_W,
    parameter int ROW_W = DPA_ROW_W
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic [1:0] policy_in,
    input wire logic [2:0] cmd_out,
    input wire logic [BANK_W-1:0] cmd_bank_out,
    input wire logic [ROW_W-1:0] cmd_row_out,
    input wire logic auto_close_flag_out,
    input wire logic [1:0] cmd_class_out
);
    logic [(1<<BANK_W)-1:0] open_ff;
    logic [ROW_W-1:0] row_ff [1<<BANK_W];
    logic acc;
    logic shut;
    assign acc = cmd_out == DPA_CMD_RD || cmd_out == DPA_CMD_WR;
    assign shut = cmd_out == DPA_CMD_CLOSE || (acc && auto_close_flag_out);
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            open_ff <= '0;
        end else if (cmd_out == DPA_CMD_ACT) begin
            open_ff[cmd_bank_out] <= 1'b1;
            row_ff[cmd_bank_out] <= cmd_row_out;
        end else if (shut) begin
            open_ff[cmd_bank_out] <= 1'b0;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_acc;
        acc;
    endsequence
    sequence s_act;
        cmd_out == DPA_CMD_ACT;
    endsequence
    AST_CLOSED_AC: assert property (
        acc && policy_in == DPA_POL_CLOSED |-> auto_close_flag_out)
        else $error("closed policy access without auto-close");
    AST_OPEN_KEEP: assert property (
        acc && policy_in == DPA_POL_OPEN |-> !auto_close_flag_out)
        else $error("open policy access closed its row");
    AST_FLAG_ACC: assert property (
        auto_close_flag_out |-> acc)
        else $error("auto-close flag without an access");
    AST_ACC_OPEN: assert property (
        s_acc |-> open_ff[cmd_bank_out])
        else $error("access to a bank with no open row");
    AST_ACC_ROW: assert property (
        s_acc |-> cmd_row_out == row_ff[cmd_bank_out])
        else $error("access to a row other than the open one");
    AST_ACT_IDLE: assert property (
        s_act |-> !open_ff[cmd_bank_out])
        else $error("open command to a bank still open");
    AST_CLOSE_TRP: assert property (
        s_act |-> !($past(shut) && $past(cmd_bank_out) == cmd_bank_out))
        else $error("open command too soon after close");
    AST_ACT_TRCD: assert property (
        s_acc |-> !($past(cmd_out) == DPA_CMD_ACT
            && $past(cmd_bank_out) == cmd_bank_out))
        else $error("access too soon after open command");
    AST_ACT_CLASS: assert property (
        s_act |-> cmd_class_out != DPA_CLS_HIT)
        else $error("open command classed as a row hit");
endmodule

bind dpa_sched dpa_sched_checker #(.BANK_W(BANK_W), .ROW_W(ROW_W)) chk_u (
    .core_clk_in, .rst_b_in, .policy_in, .cmd_out, .cmd_bank_out,
    .cmd_row_out, .auto_close_flag_out, .cmd_class_out);

// File: bench/testbench.sv
// testbench: random and corner traffic through the scheduler per policy
// assumes the memory model and the bound checker beside the design
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %0d got %0d", nm, e, g); end end
module testbench;
    import dpa_pkg::*;
    logic core_clk_in = 0;
    logic rst_b_in = 0;
    logic ce_in = 1;
    logic [1:0] policy_in = 0;
    logic req_valid_in = 0;
    logic req_write_in = 0;
    logic req_auto_close_in = 0;
    logic [DPA_BANK_W-1:0] req_bank_in = 0;
    logic [DPA_ROW_W-1:0] req_row_in = 0;
    logic req_ready_out, auto_close_flag_out, m_probe;
    logic [2:0] cmd_out;
    logic [DPA_BANK_W-1:0] cmd_bank_out;
    logic [DPA_ROW_W-1:0] cmd_row_out;
    int err_count = 0;
    int num_checks = 0;
    int m_err, m_acc, m_flag, m_close;
    dpa_sched dut_u (.core_clk_in, .rst_b_in, .ce_in, .policy_in,
        .req_valid_in, .req_write_in, .req_auto_close_in, .req_bank_in,
        .req_row_in, .req_ready_out, .cmd_out, .cmd_bank_out, .cmd_row_out,
        .auto_close_flag_out, .cmd_class_out());
    dpa_mem_model mem_u (.core_clk_in, .rst_b_in, .cmd_in(cmd_out),
        .bank_in(cmd_bank_out), .row_in(cmd_row_out),
        .flag_in(auto_close_flag_out), .err_out(m_err), .acc_out(m_acc),
        .flag_out(m_flag), .close_out(m_close), .probe_out(m_probe));
    initial forever #4 core_clk_in = ~core_clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic int exp_flags(logic [1:0] p, int n, int nf);
        if (p == DPA_POL_CLOSED)
            return n;
        return (p == DPA_POL_USER) ? nf : 0;
    endfunction
    task automatic send(input logic w, ac, input logic [2:0] b,
        input logic [13:0] r);
        int n;
        n = 0;
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_auto_close_in <= ac;
        req_bank_in <= b;
        req_row_in <= r;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (req_ready_out !== 1'b1 && n < 200);
        if (n >= 200)
            err_count++;
        @(posedge core_clk_in);
    endtask
    task automatic run(input logic [1:0] p, input int n);
        int a0, f0, c0, nf, k;
        logic ac;
        a0 = m_acc;
        f0 = m_flag;
        c0 = m_close;
        nf = 1;
        policy_in <= p;
        for (k = 0; k < n; k++) begin
            ac = 1'($urandom);
            nf += ac;
            send(1'($urandom), ac, 3'($urandom), 14'($urandom % 4));
        end
        // conflicting pair on bank 0, second arrives right behind
        send(1'b1, 1'b1, 3'h0, 14'h0);
        send(1'b1, 1'b0, 3'h0, 14'h1);
        req_valid_in <= 1'b0;
        k = 0;
        while (m_acc != a0 + n + 2 && k < 500) begin
            @(posedge core_clk_in);
            k++;
        end
        `CHK("accesses", a0 + n + 2, m_acc)
        `CHK("protocol faults", 0, m_err)
        `CHK("pair first flag", p != DPA_POL_OPEN, m_probe)
        if (p != DPA_POL_LOOK)
            `CHK("flag count", exp_flags(p, n + 2, nf), m_flag - f0)
        if (p == DPA_POL_OPEN)
            `CHK("row closes", 1'b1, m_close > c0)
        $display("test policy %0d done", p);
    endtask
    initial begin
        void'($urandom(70914));
        repeat (20) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        @(posedge core_clk_in);
        for (int p = 0; p < 4; p++)
            run(2'(p), 30);
        summarize();
    end
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule

// File: verilog/dpa_pkg.sv
// dpa_pkg: constants and types for the page-policy / auto-close scheduler
// assumes a 125 MHz controller clock, 8 ns period
package dpa_pkg;
    localparam int DPA_CLK_PS = 8000;
    // row precharge time in ps, and the cycles it takes
    localparam int DPA_TRP_PS = 15000;
    localparam int DPA_TRP_CYC = (DPA_TRP_PS + DPA_CLK_PS - 1) / DPA_CLK_PS;
    // write recovery and activate-to-column times
    localparam int DPA_TWR_PS = 15000;
    localparam int DPA_TWR_CYC = (DPA_TWR_PS + DPA_CLK_PS - 1) / DPA_CLK_PS;
    localparam int DPA_TRCD_PS = 15000;
    localparam int DPA_TRCD_CYC =
        (DPA_TRCD_PS + DPA_CLK_PS - 1) / DPA_CLK_PS;
    localparam int DPA_TMR_W = 4;
    localparam logic [3:0] DPA_TMR_RST = 4'h0;
    localparam int DPA_BANK_W = 3;
    localparam int DPA_ROW_W = 14;
    localparam int DPA_TRK_NUM = 4;

    typedef enum logic [1:0] {
        DPA_POL_OPEN = 2'b00,
        DPA_POL_CLOSED = 2'b01,
        DPA_POL_USER = 2'b10,
        DPA_POL_LOOK = 2'b11
    } dpa_policy_t;

    typedef enum logic [2:0] {
        DPA_CMD_NOP = 3'b000,
        DPA_CMD_ACT = 3'b001,
        DPA_CMD_CLOSE = 3'b010,
        DPA_CMD_RD = 3'b011,
        DPA_CMD_WR = 3'b100
    } dpa_cmd_t;

    typedef enum logic [1:0] {
        DPA_CLS_HIT = 2'b00,
        DPA_CLS_IDLE = 2'b01,
        DPA_CLS_CONFLICT = 2'b10
    } dpa_class_t;
endpackage

// File: verilog/dpa_sched.sv
// dpa_sched: page-policy and auto-close scheduler for one sdram rank
// assumes requests come from same-clock user logic with a valid/ready
// handshake and the command bus downstream takes one command per cycle
//
// Behaviour
// RL1 - a read or write can go out with the auto-close flag set.
// RL2 - the scheduler obeys a per-request auto-close input in user mode.
// RL3 - closed-page policy sets auto-close on every access.
// RL4 - open-page policy leaves the row open after each access.
// RL5 - a user-requested auto-close is honoured, so the next access only opens.
// RL6 - look-ahead checks the pending command to pick auto-close.
// RL7 - a pending hit may be issued ahead of a stalled head command.
// RL8 - with all trackers busy one is evicted for a new row.
// RL9 - without look-ahead a row change gets close then open then access.
// RL10 - with look-ahead a later conflict needs only an open command.
// RL11 - a write followed by a conflicting write carries auto-close.
// RL12 - a read after a write conflict waits recovery, close, open delays.
// RL13 - each request is classed hit, idle or conflict against trackers.
// RL14 - a bank is not opened again until row precharge time has passed.
`timescale 1ns/1ps
module dpa_sched
    import dpa_pkg::*;
#(
    parameter int TRK_NUM = DPA_TRK_NUM,
    parameter int BANK_W = DPA_BANK_W,
    parameter int ROW_W = DPA_ROW_W
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [1:0] policy_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_auto_close_in,
    input wire logic [BANK_W-1:0] req_bank_in,
    input wire logic [ROW_W-1:0] req_row_in,
    output logic req_ready_out,
    output logic [2:0] cmd_out,
    output logic [BANK_W-1:0] cmd_bank_out,
    output logic [ROW_W-1:0] cmd_row_out,
    output logic auto_close_flag_out,
    output logic [1:0] cmd_class_out
);
    initial begin
        if (TRK_NUM < 2 || TRK_NUM > 16 || BANK_W < 1 || ROW_W < 1) begin
            $error("dpa_sched: unsupported parameters");
        end
    end

    initial begin
        if (DPA_TWR_CYC + DPA_TRP_CYC >= 2**DPA_TMR_W ||
            DPA_TRCD_CYC >= 2**DPA_TMR_W) begin
            $error("dpa_sched: bank timer too narrow");
        end
    end

    localparam int IDX_W = $clog2(TRK_NUM);
    localparam int NBANK = 2**BANK_W;
    localparam logic [DPA_TMR_W-1:0] TMR_TRP = DPA_TMR_W'(DPA_TRP_CYC);
    localparam logic [DPA_TMR_W-1:0] TMR_TWR = DPA_TMR_W'(DPA_TWR_CYC);
    localparam logic [DPA_TMR_W-1:0] TMR_TRCD = DPA_TMR_W'(DPA_TRCD_CYC);
    localparam logic [DPA_TMR_W-1:0] TMR_WRP =
        DPA_TMR_W'(DPA_TWR_CYC + DPA_TRP_CYC);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(TRK_NUM - 1);

    typedef enum logic [1:0] {
        DPA_ST_IDLE = 2'b00,
        DPA_ST_SERVE = 2'b01
    } dpa_state_t;

    ////////////////////////////////////////////////////////////////////
    // two-entry command buffer: head (h) and look-ahead slot (p)
    logic h_vld_ff, nxt_h_vld, p_vld_ff, nxt_p_vld;
    logic h_wr_ff, nxt_h_wr, p_wr_ff, nxt_p_wr;
    logic h_ac_ff, nxt_h_ac, p_ac_ff, nxt_p_ac;
    logic [BANK_W-1:0] h_bank_ff, nxt_h_bank, p_bank_ff, nxt_p_bank;
    logic [ROW_W-1:0] h_row_ff, nxt_h_row, p_row_ff, nxt_p_row;
    logic rdy_ff, nxt_rdy;
    dpa_state_t st_ff, nxt_st;
    logic accept;

    // command port and per-bank timers
    logic [DPA_TMR_W-1:0] bank_tmr_ff [NBANK];
    logic [DPA_TMR_W-1:0] nxt_bank_tmr [NBANK];
    logic [2:0] cmd_ff, nxt_cmd;
    logic [BANK_W-1:0] cbank_ff, nxt_cbank;
    logic [ROW_W-1:0] crow_ff, nxt_crow;
    logic cac_ff, nxt_cac;
    logic [1:0] ccls_ff, nxt_ccls;
    logic acc_h, acc_p;

    ////////////////////////////////////////////////////////////////////
    // bank tracker pool
    logic [TRK_NUM-1:0] t_busy, t_hb, t_hr, t_pb, t_pr, t_load, t_drop;
    logic [BANK_W-1:0] t_bank [TRK_NUM];
    logic [ROW_W-1:0] t_row [TRK_NUM];
    logic [BANK_W-1:0] ld_bank;
    logic [ROW_W-1:0] ld_row;
    logic [IDX_W-1:0] evict_ff, nxt_evict;

    genvar gi;
    generate
        for (gi = 0; gi < TRK_NUM; gi++) begin : g_trk
            dpa_tracker #(.BANK_W(BANK_W), .ROW_W(ROW_W)) u_trk (
                .core_clk_in(core_clk_in),
                .rst_b_in(rst_b_in),
                .ce_in(ce_in),
                .load_in(t_load[gi]),
                .drop_in(t_drop[gi]),
                .load_bank_in(ld_bank),
                .load_row_in(ld_row),
                .look_bank_in(h_bank_ff),
                .look_row_in(h_row_ff),
                .busy_out(t_busy[gi]),
                .bank_match_out(t_hb[gi]),
                .row_match_out(t_hr[gi]),
                .bank_out(t_bank[gi]),
                .row_out(t_row[gi])
            );
            assign t_pb[gi] = t_busy[gi] && (t_bank[gi] == p_bank_ff);
            assign t_pr[gi] = t_pb[gi] && (t_row[gi] == p_row_ff);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // classification and decisions
    logic head_hit, head_open, p_hit, use_p, sel_wr, sel_ac;
    logic look_on, ac_dec, h_rdy, p_rdy, ev_rdy;
    logic [BANK_W-1:0] sel_bank, ev_bank;
    logic [ROW_W-1:0] sel_row;
    logic [IDX_W-1:0] free_idx, hit_idx, pb_idx;
    logic have_free;
    dpa_class_t h_cls;

    always_comb begin
        free_idx = '0;
        hit_idx = '0;
        pb_idx = '0;
        have_free = 1'b0;
        for (int i = TRK_NUM - 1; i >= 0; i--) begin
            if (!t_busy[i]) begin
                free_idx = IDX_W'(i);
                have_free = 1'b1;
            end
            if (t_hb[i]) begin
                hit_idx = IDX_W'(i);
            end
            if (t_pb[i]) begin
                pb_idx = IDX_W'(i);
            end
        end
        head_open = |t_hb;
        head_hit = |t_hr;
        // RL13 hit idle conflict
        if (head_hit) begin
            h_cls = DPA_CLS_HIT;
        end else if (head_open) begin
            h_cls = DPA_CLS_CONFLICT;
        end else begin
            h_cls = DPA_CLS_IDLE;
        end
        p_hit = |t_pr;
        h_rdy = (bank_tmr_ff[h_bank_ff] == DPA_TMR_RST);
        p_rdy = (bank_tmr_ff[p_bank_ff] == DPA_TMR_RST);
        ev_bank = t_bank[evict_ff];
        ev_rdy = (bank_tmr_ff[ev_bank] == DPA_TMR_RST);
        look_on = (dpa_policy_t'(policy_in) == DPA_POL_LOOK);
        // RL7 reorder pending hit
        use_p = look_on && p_vld_ff && p_hit && p_rdy && h_vld_ff &&
            !head_hit && (p_bank_ff != h_bank_ff);
        sel_wr = use_p ? p_wr_ff : h_wr_ff;
        sel_bank = use_p ? p_bank_ff : h_bank_ff;
        sel_row = use_p ? p_row_ff : h_row_ff;
        sel_ac = use_p ? p_ac_ff : h_ac_ff;
        // RL1 auto-close decision
        case (dpa_policy_t'(policy_in))
            // RL3 closed page
            DPA_POL_CLOSED: ac_dec = 1'b1;
            // RL2 RL5 user request
            DPA_POL_USER: ac_dec = sel_ac;
            // RL6 RL10 RL11 later conflict seen in buffer or at input
            DPA_POL_LOOK: ac_dec = (!use_p && p_vld_ff &&
                (p_bank_ff == sel_bank) && (p_row_ff != sel_row)) ||
                (req_valid_in && (req_bank_in == sel_bank) &&
                (req_row_in != sel_row));
            // RL4 open page
            DPA_POL_OPEN: ac_dec = 1'b0;
            default: ac_dec = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // command choice, tracker updates and bank timers
    always_comb begin
        nxt_cmd = DPA_CMD_NOP;
        nxt_cbank = cbank_ff;
        nxt_crow = crow_ff;
        nxt_cac = 1'b0;
        nxt_ccls = ccls_ff;
        nxt_evict = evict_ff;
        t_load = '0;
        t_drop = '0;
        ld_bank = h_bank_ff;
        ld_row = h_row_ff;
        acc_h = 1'b0;
        acc_p = 1'b0;
        // RL14 timers count down to zero
        for (int b = 0; b < NBANK; b++) begin
            if (bank_tmr_ff[b] == DPA_TMR_RST) begin
                nxt_bank_tmr[b] = DPA_TMR_RST;
            end else begin
                nxt_bank_tmr[b] = bank_tmr_ff[b] - 1'b1;
            end
        end
        case (st_ff)
            DPA_ST_IDLE: begin
                nxt_cmd = DPA_CMD_NOP;
            end
            DPA_ST_SERVE: begin
                if (use_p) begin
                    acc_p = 1'b1;
                end else if (head_hit && h_rdy) begin
                    acc_h = 1'b1;
                end else if (head_open && !head_hit && h_rdy) begin
                    // RL9 RL12 row change: close after recovery
                    nxt_cmd = DPA_CMD_CLOSE;
                    nxt_cbank = h_bank_ff;
                    nxt_ccls = h_cls;
                    t_drop[hit_idx] = 1'b1;
                    nxt_bank_tmr[h_bank_ff] = TMR_TRP;
                end else if (!head_open && have_free && h_rdy) begin
                    // RL9 RL10 open the row, then wait activate delay
                    nxt_cmd = DPA_CMD_ACT;
                    nxt_cbank = h_bank_ff;
                    nxt_crow = h_row_ff;
                    nxt_ccls = h_cls;
                    t_load[free_idx] = 1'b1;
                    nxt_bank_tmr[h_bank_ff] = TMR_TRCD;
                end else if (!head_open && !have_free && ev_rdy) begin
                    // RL8 on-demand flush of one tracked row
                    nxt_cmd = DPA_CMD_CLOSE;
                    nxt_cbank = ev_bank;
                    nxt_ccls = h_cls;
                    t_drop[evict_ff] = 1'b1;
                    nxt_bank_tmr[ev_bank] = TMR_TRP;
                    nxt_evict = (evict_ff == IDX_LAST) ? '0 :
                        evict_ff + 1'b1;
                end
                if (acc_h || acc_p) begin
                    // RL1 access carries the decided flag
                    nxt_cmd = sel_wr ? DPA_CMD_WR : DPA_CMD_RD;
                    nxt_cbank = sel_bank;
                    nxt_crow = sel_row;
                    nxt_cac = ac_dec;
                    nxt_ccls = use_p ? DPA_CLS_HIT : h_cls;
                    if (ac_dec) begin
                        // RL5 RL14 row shuts itself, precharge timed
                        t_drop[use_p ? pb_idx : hit_idx] = 1'b1;
                        nxt_bank_tmr[sel_bank] = sel_wr ? TMR_WRP : TMR_TRP;
                    end else if (sel_wr) begin
                        // RL12 write recovery before a close
                        nxt_bank_tmr[sel_bank] = TMR_TWR;
                    end
                end
            end
            default: nxt_cmd = DPA_CMD_NOP;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            cmd_ff <= DPA_CMD_NOP;
            cbank_ff <= '0;
            crow_ff <= '0;
            cac_ff <= 1'b0;
            ccls_ff <= DPA_CLS_IDLE;
            evict_ff <= '0;
            for (int b = 0; b < NBANK; b++) begin
                bank_tmr_ff[b] <= DPA_TMR_RST;
            end
        end else if (ce_in) begin
            cmd_ff <= nxt_cmd;
            cbank_ff <= nxt_cbank;
            crow_ff <= nxt_crow;
            cac_ff <= nxt_cac;
            ccls_ff <= nxt_ccls;
            evict_ff <= nxt_evict;
            for (int b = 0; b < NBANK; b++) begin
                bank_tmr_ff[b] <= nxt_bank_tmr[b];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // buffer refill: an issued head takes the pending entry forward
    always_comb begin
        nxt_h_vld = h_vld_ff;
        nxt_h_wr = h_wr_ff;
        nxt_h_ac = h_ac_ff;
        nxt_h_bank = h_bank_ff;
        nxt_h_row = h_row_ff;
        nxt_p_vld = p_vld_ff;
        nxt_p_wr = p_wr_ff;
        nxt_p_ac = p_ac_ff;
        nxt_p_bank = p_bank_ff;
        nxt_p_row = p_row_ff;
        accept = req_valid_in && rdy_ff;
        if (acc_h) begin
            nxt_h_vld = p_vld_ff;
            nxt_h_wr = p_wr_ff;
            nxt_h_ac = p_ac_ff;
            nxt_h_bank = p_bank_ff;
            nxt_h_row = p_row_ff;
            nxt_p_vld = 1'b0;
        end else if (acc_p) begin
            nxt_p_vld = 1'b0;
        end
        if (accept) begin
            if (!nxt_h_vld) begin
                nxt_h_vld = 1'b1;
                nxt_h_wr = req_write_in;
                nxt_h_ac = req_auto_close_in;
                nxt_h_bank = req_bank_in;
                nxt_h_row = req_row_in;
            end else begin
                nxt_p_vld = 1'b1;
                nxt_p_wr = req_write_in;
                nxt_p_ac = req_auto_close_in;
                nxt_p_bank = req_bank_in;
                nxt_p_row = req_row_in;
            end
        end
        nxt_rdy = !nxt_p_vld;
        nxt_st = nxt_h_vld ? DPA_ST_SERVE : DPA_ST_IDLE;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            h_vld_ff <= 1'b0;
            h_wr_ff <= 1'b0;
            h_ac_ff <= 1'b0;
            h_bank_ff <= '0;
            h_row_ff <= '0;
            p_vld_ff <= 1'b0;
            p_wr_ff <= 1'b0;
            p_ac_ff <= 1'b0;
            p_bank_ff <= '0;
            p_row_ff <= '0;
            rdy_ff <= 1'b0;
            st_ff <= DPA_ST_IDLE;
        end else if (ce_in) begin
            h_vld_ff <= nxt_h_vld;
            h_wr_ff <= nxt_h_wr;
            h_ac_ff <= nxt_h_ac;
            h_bank_ff <= nxt_h_bank;
            h_row_ff <= nxt_h_row;
            p_vld_ff <= nxt_p_vld;
            p_wr_ff <= nxt_p_wr;
            p_ac_ff <= nxt_p_ac;
            p_bank_ff <= nxt_p_bank;
            p_row_ff <= nxt_p_row;
            rdy_ff <= nxt_rdy;
            st_ff <= nxt_st;
        end
    end

    assign req_ready_out = rdy_ff;
    assign cmd_out = cmd_ff;
    assign cmd_bank_out = cbank_ff;
    assign cmd_row_out = crow_ff;
    assign auto_close_flag_out = cac_ff;
    assign cmd_class_out = ccls_ff;
endmodule

// File: verilog/dpa_tracker.sv
// dpa_tracker: one bank tracker entry holding the bank and row of an open row
// assumes the scheduler grants load/clear strobes one at a time
`timescale 1ns/1ps
module dpa_tracker
    import dpa_pkg::*;
#(
    parameter int BANK_W = DPA_BANK_W,
    parameter int ROW_W = DPA_ROW_W
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic load_in,
    input wire logic drop_in,
    input wire logic [BANK_W-1:0] load_bank_in,
    input wire logic [ROW_W-1:0] load_row_in,
    input wire logic [BANK_W-1:0] look_bank_in,
    input wire logic [ROW_W-1:0] look_row_in,
    output logic busy_out,
    output logic bank_match_out,
    output logic row_match_out,
    output logic [BANK_W-1:0] bank_out,
    output logic [ROW_W-1:0] row_out
);
    logic busy_ff, nxt_busy;
    logic [BANK_W-1:0] bank_ff, nxt_bank;
    logic [ROW_W-1:0] row_ff, nxt_row;

    always_comb begin
        nxt_busy = busy_ff;
        nxt_bank = bank_ff;
        nxt_row = row_ff;
        if (drop_in) begin
            nxt_busy = 1'b0;
        end
        if (load_in) begin
            nxt_busy = 1'b1;
            nxt_bank = load_bank_in;
            nxt_row = load_row_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            busy_ff <= 1'b0;
            bank_ff <= '0;
            row_ff <= '0;
        end else if (ce_in) begin
            busy_ff <= nxt_busy;
            bank_ff <= nxt_bank;
            row_ff <= nxt_row;
        end
    end

    assign busy_out = busy_ff;
    assign bank_out = bank_ff;
    assign row_out = row_ff;
    assign bank_match_out = busy_ff && (bank_ff == look_bank_in);
    assign row_match_out = busy_ff && (bank_ff == look_bank_in) &&
        (row_ff == look_row_in);
endmodule
